//--- hdl/isec_regs.sv
// Status, enable, control, base and entry-address registers of a 48-source interrupt controller.
// Assumes APB3 master, source events synchronous to pclk, class map supplied by a prioritizer.
//
// Summary of operation
// [R01] Upper fast status bits 15..0 show sources 32..47; zero means pending.
// [R02] Writing one to a status bit acknowledges it and returns it to one.
// [R03] Lower normal status bits 31..1 show sources 1..31 mapped normal.
// [R04] Source 0 is always fast; lower normal status bit 0 reads one.
// [R05] Upper normal status bits 15..0 show sources 32..47 mapped normal.
// [R06] Fast entry address is read-only, 29 bits, top three bits zero.
// [R07] Normal entry address is read-only, 29 bits, top three bits zero.
// [R08] Lower enable bits 31..1 enable sources 1..31, one enables.
// [R09] Source 0 is non-maskable; its enable bit always reads one.
// [R10] Upper enable bits 15..0 enable sources 32..47; bits 31..16 read zero.
// [R11] Control bit 1 lets disabled pending sources into normal entry choice.
// [R12] Control bit 0 lets disabled pending sources into fast entry choice.
// [R13] Disable mode 0 masks at once; mode 1 masks only after acknowledge.
// [R14] Entry equals base plus winner-plus-one times entry size, always current.
// [R15] Size code 0..3 selects 4, 8, 16 or 32 bytes per entry.
// [R16] With no qualifying source pending, entry address equals the base.
// [R17] Reserved bits ignore writes; writing zero to a status bit does nothing.
// [R18] Request outputs stay high while a pending enabled source of that class exists.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "isec_map.svh"
module isec_regs #(
   parameter int NUM_SRC = 48
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sources and class map (1 = fast)
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic [NUM_SRC-1:0] src_is_fast,
   // Requests to the processor
   output logic fast_request,
   output logic normal_request
);
   if (NUM_SRC < 33 || NUM_SRC > 64) begin : g_bad_num_src
      $error("isec_regs: NUM_SRC must lie in 33..64");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Winner search: lowest source number wins
   function automatic isec_pkg::isec_idx_t first_set(input isec_pkg::isec_vec_t v);
      isec_pkg::isec_idx_t r;
      r = 6'h00;
      for (int i = 63; i >= 0; i--) begin
         if (v[i]) begin
            r = 6'(i);
         end
      end
      return r;
   endfunction

   function automatic isec_pkg::isec_addr_t entry_of(input isec_pkg::isec_vec_t q,
                                                    input isec_pkg::isec_addr_t base,
                                                    input isec_pkg::isec_size_t sz);
      isec_pkg::isec_addr_t step;
      step = 29'(first_set(q)) + 29'h0000001;
      if (q == 64'h0) begin
         return base; // [R16]
      end
      // Widened shift amount, so codes 2 and 3 do not wrap to 0 and 1
      return 29'(base + (step << (3'(sz) + 3'h2))); // [R14] [R15]
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State
   isec_pkg::isec_vec_t pend_q, pend_d;
   isec_pkg::isec_vec_t en_q, en_d;
   isec_pkg::isec_vec_t lat_q, lat_d;
   logic [2:0] ctrl_q, ctrl_d;
   logic [25:0] base_q, base_d;
   isec_pkg::isec_size_t size_q, size_d;
   logic [31:0] rdata_q, rdata_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   localparam isec_pkg::isec_vec_t SRC_MASK = isec_pkg::isec_vec_t'((65'h1 << NUM_SRC) - 65'h1);
   wire logic setup = psel & ~penable;
   wire logic wr = psel & penable & pwrite;
   wire logic hit_fast_lo = paddr == `ISEC_OFS_FAST_LO;
   wire logic hit_fast_hi = paddr == `ISEC_OFS_FAST_HI;
   wire logic hit_norm_lo = paddr == `ISEC_OFS_NORM_LO;
   wire logic hit_norm_hi = paddr == `ISEC_OFS_NORM_HI;
   wire logic hit_fast_ent = paddr == `ISEC_OFS_FAST_ENTRY;
   wire logic hit_norm_ent = paddr == `ISEC_OFS_NORM_ENTRY;
   wire logic hit_en_lo = paddr == `ISEC_OFS_EN_LO;
   wire logic hit_en_hi = paddr == `ISEC_OFS_EN_HI;
   wire logic hit_ctrl = paddr == `ISEC_OFS_CTRL;
   wire logic hit_base = paddr == `ISEC_OFS_BASE;
   wire logic mapped = hit_fast_lo | hit_fast_hi | hit_norm_lo | hit_norm_hi | hit_fast_ent
      | hit_norm_ent | hit_en_lo | hit_en_hi | hit_ctrl | hit_base;

   ////////////////////////////////////////////////////////////////////////////////
   // Classes, enables and qualification
   wire isec_pkg::isec_vec_t evt = {{(64 - NUM_SRC){1'b0}}, src_event};
   wire isec_pkg::isec_vec_t fast_map = {{(64 - NUM_SRC){1'b0}}, src_is_fast} | 64'h1; // [R04]
   wire isec_pkg::isec_vec_t norm_map = ~fast_map & SRC_MASK;
   wire isec_pkg::isec_vec_t en_vis = (en_q | 64'h1) & SRC_MASK; // [R09]
   // Delayed mode keeps the enable seen when the event arrived
   wire isec_pkg::isec_vec_t eff_en = ctrl_q[`ISEC_CTRL_DIS_MODE] ? lat_q : en_vis; // [R13]
   wire isec_pkg::isec_vec_t fast_pend = pend_q & fast_map;
   wire isec_pkg::isec_vec_t norm_pend = pend_q & norm_map;
   wire isec_pkg::isec_vec_t fast_qual = fast_pend
      & (eff_en | {64{ctrl_q[`ISEC_CTRL_FAST_REFLECT]}}); // [R12]
   wire isec_pkg::isec_vec_t norm_qual = norm_pend
      & (eff_en | {64{ctrl_q[`ISEC_CTRL_NORM_REFLECT]}}); // [R11]
   wire isec_pkg::isec_addr_t base_addr = {base_q, 3'h0};
   wire isec_pkg::isec_addr_t fast_entry = entry_of(fast_qual, base_addr, size_q);
   wire isec_pkg::isec_addr_t norm_entry = entry_of(norm_qual, base_addr, size_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Status images: zero marks a pending source
   wire isec_pkg::isec_vec_t fast_img = ~fast_pend;
   wire isec_pkg::isec_vec_t norm_img = ~norm_pend | 64'h1; // [R04]
   wire isec_pkg::isec_vec_t wvec_lo = {32'h0000_0000, pwdata};
   wire isec_pkg::isec_vec_t wvec_hi = {pwdata, 32'h0000_0000};
   wire isec_pkg::isec_vec_t ack = ({64{wr & hit_fast_lo}} & wvec_lo & fast_map)
      | ({64{wr & hit_fast_hi}} & wvec_hi & fast_map)
      | ({64{wr & hit_norm_lo}} & wvec_lo & norm_map)
      | ({64{wr & hit_norm_hi}} & wvec_hi & norm_map); // [R02] [R17]

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      pend_d = ((pend_q & ~ack) | evt) & SRC_MASK; // [R02]
      lat_d = lat_q;
      for (int i = 0; i < 64; i++) begin
         if (!pend_q[i] || ack[i]) begin
            lat_d[i] = en_vis[i]; // [R13]
         end
      end
      en_d = en_q;
      if (wr && hit_en_lo) begin
         en_d[31:0] = {pwdata[31:1], 1'b1}; // [R08] [R09]
      end
      if (wr && hit_en_hi) begin
         en_d[63:32] = pwdata; // [R10]
      end
      en_d = en_d & SRC_MASK; // [R17]
      ctrl_d = ctrl_q;
      if (wr && hit_ctrl) begin
         ctrl_d = pwdata[2:0]; // [R17]
      end
      base_d = base_q;
      size_d = size_q;
      if (wr && hit_base) begin
         base_d = pwdata[`ISEC_BASE_MSB:`ISEC_BASE_LSB];
         size_d = pwdata[`ISEC_SIZE_MSB:`ISEC_SIZE_LSB]; // [R15]
      end
   end

   // Read data is captured in the setup cycle and shown during access
   wire logic [31:0] rd_mux =
        hit_fast_lo ? fast_img[31:0]
      : hit_fast_hi ? fast_img[63:32] // [R01]
      : hit_norm_lo ? norm_img[31:0] // [R03] [R04]
      : hit_norm_hi ? norm_img[63:32] // [R05]
      : hit_fast_ent ? {3'h0, fast_entry} // [R06]
      : hit_norm_ent ? {3'h0, norm_entry} // [R07]
      : hit_en_lo ? en_vis[31:0] // [R08] [R09]
      : hit_en_hi ? en_vis[63:32] // [R10]
      : hit_ctrl ? {29'h0000_0000, ctrl_q}
      : hit_base ? {3'h0, base_q, 1'b0, 2'(size_q)}
      : 32'h0000_0000;
   assign rdata_d = setup ? rd_mux : rdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 64'h0;
         en_q <= `ISEC_RST_EN;
         lat_q <= 64'h0;
         ctrl_q <= `ISEC_RST_CTRL;
         base_q <= `ISEC_RST_BASE;
         size_q <= `ISEC_RST_SIZE;
         rdata_q <= 32'h0000_0000;
      end else begin
         pend_q <= pend_d;
         en_q <= en_d;
         lat_q <= lat_d;
         ctrl_q <= ctrl_d;
         base_q <= base_d;
         size_q <= size_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = rdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign fast_request = |(fast_pend & eff_en); // [R18]
   assign normal_request = |(norm_pend & eff_en); // [R18]

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ack_clears_a: assert property ((wr && hit_fast_hi && pwdata[0] && !src_event[32]
      && fast_map[32]) |=> !pend_q[32]) // [R02]
      else $error("acknowledge did not clear pending source");
   event_sets_a: assert property (src_event[5] |=> pend_q[5]) // [R02]
      else $error("event not captured");
   zero_write_keeps_a: assert property ((wr && hit_norm_lo && !pwdata[7] && !src_event[7])
      |=> pend_q[7] == $past(pend_q[7])) // [R17]
      else $error("writing zero changed status");
   src0_fast_a: assert property ((setup && hit_norm_lo) |=> prdata[0]) // [R04]
      else $error("normal status bit 0 not one");
   en0_fixed_a: assert property ((setup && hit_en_lo) |=> prdata[0]) // [R09]
      else $error("enable bit 0 not one");
   en_hi_rsvd_a: assert property ((setup && hit_en_hi) |=> prdata[31:16] == 16'h0000) // [R10]
      else $error("reserved enable bits not zero");
   entry_top_a: assert property ((setup && (hit_fast_ent || hit_norm_ent))
      |=> prdata[31:29] == 3'h0) // [R06] [R07]
      else $error("entry address top bits not zero");
   idle_base_a: assert property ((norm_qual == 64'h0) |-> norm_entry == base_addr) // [R16]
      else $error("idle entry differs from base");
   entry_calc_a: assert property ((fast_qual[0] && size_q == 2'h3)
      |-> fast_entry == 29'(base_addr + 29'h20)) // [R14] [R15]
      else $error("fast entry for source 0 wrong");
   imm_mask_a: assert property ((!ctrl_q[`ISEC_CTRL_DIS_MODE] && fast_pend == 64'h1
      && !ctrl_q[`ISEC_CTRL_FAST_REFLECT]) |-> fast_request) // [R13] [R18]
      else $error("non-maskable source did not raise fast request");
   delay_hold_a: assert property ((ctrl_q[`ISEC_CTRL_DIS_MODE] && norm_pend[3] && lat_q[3]
      && !ack[3]) |=> lat_q[3]) // [R13]
      else $error("delayed mode dropped latched enable");
   reflect_a: assert property ((ctrl_q[`ISEC_CTRL_NORM_REFLECT] && norm_pend != 64'h0)
      |-> norm_entry != base_addr) // [R11]
      else $error("reflect mode ignored masked source");
   slverr_a: assert property ((psel && penable && !mapped) |-> pslverr) // [R17]
      else $error("unmapped access not refused");

   // Status images and reserved control bits as seen by a read
   fast_hi_img_a: assert property ((setup && hit_fast_hi) |=> // [R01]
      prdata == {16'hFFFF, ~$past(pend_q[47:32] & fast_map[47:32])})
      else $error("upper fast status image wrong");
   norm_lo_img_a: assert property ((setup && hit_norm_lo) |=> // [R03]
      prdata[31:1] == ~$past(pend_q[31:1] & norm_map[31:1]))
      else $error("lower normal status image wrong");
   norm_hi_img_a: assert property ((setup && hit_norm_hi) |=> // [R05]
      prdata == {16'hFFFF, ~$past(pend_q[47:32] & norm_map[47:32])})
      else $error("upper normal status image wrong");
   ctrl_rsvd_a: assert property ((setup && hit_ctrl) |=> // [R17]
      prdata[31:3] == 29'h0)
      else $error("reserved control bits not zero");

   // Register writes
   en_lo_write_a: assert property ((wr && hit_en_lo) |=> // [R08]
      en_vis[31:1] == $past(pwdata[31:1]))
      else $error("lower enable write not taken");
   en_hi_write_a: assert property ((wr && hit_en_hi) |=> // [R10]
      en_vis[63:32] == ($past(pwdata) & SRC_MASK[63:32]))
      else $error("upper enable write not taken");
   base_write_a: assert property ((wr && hit_base) |=> // [R15]
      base_q == $past(pwdata[`ISEC_BASE_MSB:`ISEC_BASE_LSB])
      && size_q == $past(pwdata[`ISEC_SIZE_MSB:`ISEC_SIZE_LSB]))
      else $error("base or size write not taken");
   ro_entry_a: assert property ((wr && (hit_fast_ent || hit_norm_ent)) |=> // [R06] [R07]
      en_q == $past(en_q) && ctrl_q == $past(ctrl_q) && base_q == $past(base_q))
      else $error("write to entry register changed state");

   // Acknowledge by class
   ack_norm_a: assert property ((wr && hit_norm_lo && pwdata[9] && norm_map[9] // [R02]
      && !src_event[9]) |=> !pend_q[9])
      else $error("normal acknowledge did not clear pending source");
   ack_cross_a: assert property ((wr && hit_fast_lo && pwdata[9] && norm_map[9] // [R17]
      && !src_event[9]) |=> pend_q[9] == $past(pend_q[9]))
      else $error("fast acknowledge cleared a normal source");

   // Entry choice and masking modes
   fast_reflect_a: assert property ((ctrl_q[`ISEC_CTRL_FAST_REFLECT] // [R12]
      && fast_pend != 64'h0) |-> fast_entry != base_addr)
      else $error("fast reflect mode ignored masked source");
   size_step_a: assert property (norm_qual[1] |-> // [R14] [R15]
      norm_entry == 29'(base_addr + (29'h0000008 << size_q)))
      else $error("normal entry for source 1 wrong");
   imm_off_a: assert property ((!ctrl_q[`ISEC_CTRL_DIS_MODE] && wr && hit_en_lo // [R13]
      && pwdata[31:1] == 31'h0 && norm_pend[63:32] == 32'h0000_0000
      && evt == 64'h0) |=> !normal_request)
      else $error("immediate disable left normal request up");
   delay_keep_a: assert property ((ctrl_q[`ISEC_CTRL_DIS_MODE] && norm_pend[3] // [R13] [R18]
      && lat_q[3] && !en_vis[3]) |-> normal_request)
      else $error("delayed disable dropped normal request");

   cov_fast_c: cover property (fast_request && normal_request);
   cov_ack_c: cover property (wr && hit_norm_hi && ack != 64'h0);
   cov_delay_c: cover property (ctrl_q[`ISEC_CTRL_DIS_MODE] && norm_pend[3] && !en_vis[3]
      && normal_request);
   cov_reflect_c: cover property (ctrl_q[`ISEC_CTRL_FAST_REFLECT]
      && fast_qual != (fast_pend & eff_en));
   cov_size_c: cover property (norm_qual != 64'h0 && size_q == 2'h3);
endmodule

//--- common/isec_map.svh
// Register offsets, field positions, reset values for the interrupt status/enable/entry block.
// Assumes a 32-bit APB slave with byte addresses taken as printed.
`ifndef ISEC_MAP_SVH
`define ISEC_MAP_SVH
`define ISEC_OFS_FAST_LO 12'h000
`define ISEC_OFS_FAST_HI 12'h004
`define ISEC_OFS_NORM_LO 12'h008
`define ISEC_OFS_NORM_HI 12'h00C
`define ISEC_OFS_FAST_ENTRY 12'h010
`define ISEC_OFS_NORM_ENTRY 12'h014
`define ISEC_OFS_EN_LO 12'h018
`define ISEC_OFS_EN_HI 12'h01C
`define ISEC_OFS_CTRL 12'h020
`define ISEC_OFS_BASE 12'h024
`define ISEC_CTRL_FAST_REFLECT 0
`define ISEC_CTRL_NORM_REFLECT 1
`define ISEC_CTRL_DIS_MODE 2
`define ISEC_BASE_LSB 3
`define ISEC_BASE_MSB 28
`define ISEC_SIZE_LSB 0
`define ISEC_SIZE_MSB 1
`define ISEC_RST_CTRL 3'h0
`define ISEC_RST_EN 64'h0000_0000_0000_0000
`define ISEC_RST_BASE 26'h000_0000
`define ISEC_RST_SIZE 2'h0
`define ISEC_ACCESS_CYCLES 1
`endif

//--- common/isec_pkg.sv
// Types shared by the interrupt status/enable/entry block.
// Assumes at most 64 sources and a 29-bit entry address space.
package isec_pkg;
   typedef logic [63:0] isec_vec_t;
   typedef logic [28:0] isec_addr_t;
   typedef logic [1:0] isec_size_t;
   typedef logic [5:0] isec_idx_t;
endpackage

//--- sim/isec_src_model.sv
// Event source model that stands in for the peripherals raising interrupt events.
// Assumes the bench asks for one burst at a time through ev_go on a rising pclk edge.
`timescale 1ns/10ps
module isec_src_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Burst request from the bench
   input wire logic ev_go,
   input wire logic [47:0] ev_vec,
   // Events to the controller
   output logic [47:0] src_event
);
   // One-cycle pulse per burst, lines idle low in between
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         src_event <= 48'h0000_0000_0000;
      else
         src_event <= ev_go ? ev_vec : 48'h0000_0000_0000;
   end
endmodule

//--- sim/isec_regs_tb.sv
// Self-checking bench for the interrupt status, enable and entry-address registers.
// Assumes a zero-wait APB slave and events that are one pclk cycle long.
`timescale 1ns/10ps
`include "isec_map.svh"
module isec_regs_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic ev_go = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, fast_request, normal_request;
   logic [47:0] src_event, ev_vec = 48'h0, src_is_fast = 48'h0;
   logic [47:0] m_pend, m_en, m_lat, m_fast;
   logic [2:0] m_ctrl;
   logic [25:0] m_base;
   logic [1:0] m_size;
   logic [63:0] rnd;
   logic [33:0] exp_q[$];
   integer seed = 32'hD769EF31;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #5 pclk = ~pclk;
   isec_regs #(.NUM_SRC(48)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_event(src_event), .src_is_fast(src_is_fast),
      .fast_request(fast_request), .normal_request(normal_request));
   isec_src_model src (.pclk(pclk), .presetn(presetn), .ev_go(ev_go), .ev_vec(ev_vec),
      .src_event(src_event));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Effective enables: in delayed mode a pending source keeps the enable it had
   function automatic logic [47:0] eff();
      return m_ctrl[2] ? ((m_lat & m_pend) | (m_en & ~m_pend)) : m_en;
   endfunction
   function automatic logic [31:0] entry(input logic [47:0] qual);
      logic [31:0] e;
      e = {3'b000, m_base, 3'b000};
      for (int n = 47; n >= 0; n--)
         if (qual[n]) e = {3'b000, m_base, 3'b000} + ((n + 1) << (m_size + 2));
      return {3'b000, e[28:0]};
   endfunction
   function automatic logic [31:0] model(input logic [11:0] a);
      logic [47:0] f, q;
      f = m_pend & m_fast;
      q = m_pend & ~m_fast;
      case (a)
         `ISEC_OFS_FAST_LO: return ~f[31:0];
         `ISEC_OFS_FAST_HI: return {16'hFFFF, ~f[47:32]};
         `ISEC_OFS_NORM_LO: return ~q[31:0] | 32'h0000_0001;
         `ISEC_OFS_NORM_HI: return {16'hFFFF, ~q[47:32]};
         `ISEC_OFS_FAST_ENTRY: return entry(f & (m_ctrl[0] ? '1 : eff()));
         `ISEC_OFS_NORM_ENTRY: return entry(q & (m_ctrl[1] ? '1 : eff()));
         `ISEC_OFS_EN_LO: return m_en[31:0];
         `ISEC_OFS_EN_HI: return {16'h0000, m_en[47:32]};
         `ISEC_OFS_CTRL: return {29'h0, m_ctrl};
         `ISEC_OFS_BASE: return {3'b000, m_base, 1'b0, m_size};
         default: return 32'h0000_0000;
      endcase
   endfunction
   task automatic upd(input logic [11:0] a, input logic [31:0] d);
      case (a)
         `ISEC_OFS_FAST_LO: m_pend[31:0] &= ~(d & m_fast[31:0]);
         `ISEC_OFS_FAST_HI: m_pend[47:32] &= ~(d[15:0] & m_fast[47:32]);
         `ISEC_OFS_NORM_LO: m_pend[31:0] &= ~(d & ~m_fast[31:0]);
         `ISEC_OFS_NORM_HI: m_pend[47:32] &= ~(d[15:0] & ~m_fast[47:32]);
         `ISEC_OFS_EN_LO: m_en[31:0] = d | 32'h0000_0001;
         `ISEC_OFS_EN_HI: m_en[47:32] = d[15:0];
         `ISEC_OFS_CTRL: m_ctrl = d[2:0];
         `ISEC_OFS_BASE: {m_base, m_size} = {d[28:3], d[1:0]};
         default: ;
      endcase
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back({~w, a > `ISEC_OFS_BASE, w ? 32'h0 : model(a)});
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (w) upd(a, d);
   endtask
   task automatic readall();
      for (int a = 0; a <= 48; a += 4)
         apb(1'b0, a[11:0], 32'h0);
   endtask
   task automatic reqchk();
      logic [1:0] rq;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      rq = {|(m_pend & m_fast & eff()), |(m_pend & ~m_fast & eff())};
      check({30'h0, fast_request, normal_request}, {30'h0, rq});
   endtask
   task automatic fire(input logic [47:0] v);
      @(posedge pclk);
      ev_vec <= v;
      ev_go <= 1'b1;
      @(posedge pclk);
      ev_go <= 1'b0;
      @(posedge pclk);
      m_lat = (m_lat & m_pend) | (m_en & ~m_pend);
      m_pend |= v;
      reqchk();
   endtask
   // Result watcher: every completed transfer retires the oldest note
   always @(posedge pclk) begin
      logic [33:0] e;
      cycles++;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]});
         if (e[33]) check(prdata, e[31:0]);
      end
      if (cycles == 30000) begin
         miscompares++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rnd = {$random(seed), $random(seed)};
      src_is_fast <= rnd[47:0];
      m_fast = rnd[47:0] | 48'h1;
      m_pend = '0;
      m_en = 48'h1;
      m_lat = 48'h1;
      m_ctrl = '0;
      {m_base, m_size} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      readall();
      for (int k = 0; k < 8; k++) begin
         rnd = {$random(seed), $random(seed)};
         apb(1'b1, `ISEC_OFS_EN_LO, rnd[31:0]);
         apb(1'b1, `ISEC_OFS_EN_HI, rnd[63:32]);
         apb(1'b1, `ISEC_OFS_CTRL, {rnd[40:12], k[2:0]});
         apb(1'b1, `ISEC_OFS_BASE, {rnd[29:0], k[1:0]});
         apb(1'b1, `ISEC_OFS_FAST_ENTRY, rnd[63:32]);
         apb(1'b1, 12'h030, rnd[31:0]);
         fire(rnd[47:0] & rnd[63:16]);
         readall();
         for (int a = 0; a <= 12; a += 4)
            apb(1'b1, a[11:0], $random(seed));
         reqchk();
         readall();
         apb(1'b1, `ISEC_OFS_EN_LO, 32'h0000_0000);
         apb(1'b1, `ISEC_OFS_EN_HI, 32'h0000_0000);
         reqchk();
         readall();
         for (int a = 0; a <= 12; a += 4)
            apb(1'b1, a[11:0], 32'hFFFF_FFFF);
         reqchk();
      end
      repeat (2) @(posedge pclk);
      check(exp_q.size(), 32'h0);
      finish_test();
   end
endmodule
